//--- tb_top.sv
// bench for the vendor fault status register bank
// assumes the host model as the only requester; clock enable from the bench
`timescale 1ns/10ps
module tb_top;
    typedef struct packed {
        logic       ch;
        logic [2:0] cfg;
        logic [2:0] mx;
        logic [2:0] hot;
        logic [7:0] hv;
    } vfs_row_t;

    logic                         ref_clk   = 1'b0;
    logic                         reset     = 1'b1;
    logic                         clk_en    = 1'b1;
    logic [1:0]                   fault_pin = 2'h0;
    logic [1:0]                   tsns_pin  = 2'h0;
    vfs_pkg::vfs_evt_t [1:0]      evt       = '0;
    logic [1:0][5:0][7:0]         temp      = '0;
    vfs_pkg::vfs_req_t            req;
    logic                         ack;
    logic [7:0]                   rd;
    logic [1:0][2:0]              op;
    logic [1:0][7:0]              rt;
    logic [7:0]                   q;
    vfs_row_t                     r;
    int                           num_errors = 0;
    int                           n_checks   = 0;
    vfs_row_t                     rows [5] = '{
        '{1'b0, 3'h7, 3'h6, 3'h0, 8'hFF}, '{1'b0, 3'h6, 3'h6, 3'h5, 8'h11},
        '{1'b1, 3'h3, 3'h2, 3'h2, 8'h80}, '{1'b1, 3'h2, 3'h3, 3'h1, 8'h7F},
        '{1'b1, 3'h1, 3'h0, 3'h4, 8'h20}};

    always #2.5 ref_clk = ~ref_clk;

    vfs_status vfs_status_i (
        .ref_clk_i(ref_clk), .reset_i(reset), .clk_en_i(clk_en),
        .stage_fault_pin_i(fault_pin), .tsns_high_pin_i(tsns_pin),
        .evt_i(evt), .stage_temp_i(temp), .req_i(req), .ack_o(ack),
        .rd_data_o(rd), .op_phases_o(op), .rail_temp_o(rt));

    vfs_host_model vfs_host_model_i (
        .ref_clk_i(ref_clk), .ack_i(ack), .rd_data_i(rd), .req_o(req));

    task automatic check(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic rdc(input logic [7:0] pg, input logic s,
                       input logic [7:0] e);
        vfs_host_model_i.xfer(1'b0, s, pg, 8'h00, q);
        check(q, e);
    endtask

    task automatic wr(input logic [7:0] pg, input logic [7:0] d);
        vfs_host_model_i.xfer(1'b1, 1'b0, pg, d, q);
    endtask

    // k: sense_open, vid_reset, tsns_check, imb_sample, one cycle high
    task automatic ev(input int c, input logic [3:0] k, input logic [5:0] p);
        @(posedge ref_clk);
        #1 evt[c][15:6] = {k, p};
        @(posedge ref_clk);
        #1 evt[c][15:6] = 10'h000;
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge ref_clk);
        num_errors++;
        results();
    end

    initial begin
        repeat (20) @(posedge ref_clk);
        #1 reset = 1'b0;
        rdc(8'h00, 1'b0, 8'h00);
        rdc(8'h01, 1'b0, 8'h00);
        check({5'h00, op[0]}, 8'h00);
        check(rt[1], 8'h00);
        $display("test reset done");
        foreach (rows[i]) begin
            r = rows[i];
            @(posedge ref_clk);
            #1 evt[r.ch].cfg_phases = r.cfg;
            evt[r.ch].max_phases = r.mx;
            temp[r.ch] = {6{8'h10}};
            temp[r.ch][r.hot] = r.hv;
            repeat (2) @(posedge ref_clk);
            #1;
            check({5'h00, op[r.ch]},
                  {5'h00, (r.cfg > r.mx) ? r.mx : r.cfg});
            check(rt[r.ch], r.hv);
            rdc({7'h00, r.ch}, 1'b0,
                (r.cfg > r.mx) ? 8'h20 : 8'h00);
            evt[r.ch].cfg_phases = 3'h0;
            wr({7'h00, r.ch}, 8'h20);
            rdc({7'h00, r.ch}, 1'b0, 8'h00);
        end
        $display("test rows done");
        fault_pin = 2'h2;
        repeat (8) @(posedge ref_clk);
        rdc(8'h01, 1'b0, 8'h80);
        rdc(8'h00, 1'b0, 8'h00);
        wr(8'h01, 8'h80);
        rdc(8'h01, 1'b0, 8'h80);
        fault_pin = 2'h0;
        repeat (8) @(posedge ref_clk);
        rdc(8'h01, 1'b0, 8'h80);
        wr(8'h01, 8'h00);
        rdc(8'h01, 1'b0, 8'h80);
        wr(8'h01, 8'h80);
        rdc(8'h01, 1'b0, 8'h00);
        $display("test stage fault done");
        ev(0, 4'h8, 6'h00);
        rdc(8'hFF, 1'b0, 8'h40);
        rdc(8'h01, 1'b0, 8'h00);
        ev(0, 4'h4, 6'h00);
        ev(1, 4'h4, 6'h00);
        rdc(8'h00, 1'b0, 8'h48);
        rdc(8'h01, 1'b0, 8'h00);
        rdc(8'h02, 1'b0, 8'h00);
        wr(8'h02, 8'hFF);
        rdc(8'h00, 1'b0, 8'h48);
        wr(8'hFF, 8'h48);
        rdc(8'h00, 1'b0, 8'h00);
        $display("test sense and vid done");
        tsns_pin = 2'h1;
        repeat (8) @(posedge ref_clk);
        ev(0, 4'h2, 6'h00);
        rdc(8'h00, 1'b0, 8'h10);
        tsns_pin = 2'h0;
        repeat (8) @(posedge ref_clk);
        ev(0, 4'h2, 6'h00);
        rdc(8'h00, 1'b0, 8'h10);
        wr(8'h00, 8'h10);
        ev(0, 4'h2, 6'h00);
        rdc(8'h00, 1'b0, 8'h00);
        $display("test temp sense done");
        for (int i = 0; i < 13; i++)
            ev(1, 4'h1, (i == 6) ? 6'h00 : ((i % 2) ? 6'h01 : 6'h04));
        rdc(8'h01, 1'b0, 8'h00);
        ev(1, 4'h1, 6'h20);
        rdc(8'h01, 1'b0, 8'h01);
        rdc(8'h01, 1'b1, 8'h25);
        // a write with the detail select must not touch the status flags
        vfs_host_model_i.xfer(1'b1, 1'b1, 8'h01, 8'h01, q);
        rdc(8'h01, 1'b0, 8'h01);
        wr(8'h01, 8'h01);
        rdc(8'h01, 1'b0, 8'h00);
        rdc(8'h01, 1'b1, 8'h00);
        $display("test imbalance done");
        // an event while the clock enable is low is lost with the frozen state
        clk_en = 1'b0;
        ev(0, 4'h8, 6'h00);
        clk_en = 1'b1;
        rdc(8'h00, 1'b0, 8'h00);
        ev(0, 4'h8, 6'h00);
        ev(1, 4'h1, 6'h02);
        rdc(8'h00, 1'b0, 8'h40);
        rdc(8'h01, 1'b1, 8'h02);
        $display("test clock enable done");
        @(posedge ref_clk);
        #1 reset = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1 reset = 1'b0;
        rdc(8'h00, 1'b0, 8'h00);
        rdc(8'h01, 1'b1, 8'h00);
        $display("test mid-run reset done");
        results();
    end
endmodule

//--- vfs_host_model.sv
// host model: issues byte reads and writes on the status request port
// assumes the bench calls xfer from one process, one transfer at a time
`timescale 1ns/10ps
module vfs_host_model (
    input  wire logic         ref_clk_i,
    input  wire logic         ack_i,
    input  wire logic [7:0]   rd_data_i,
    output vfs_pkg::vfs_req_t req_o
);
    initial req_o = '0;

    // a missing answer reads as EEh so the caller's compare fails
    task automatic xfer(input logic w, input logic s, input logic [7:0] pg,
                        input logic [7:0] d, output logic [7:0] q);
        int n;
        @(posedge ref_clk_i);
        #1 req_o = {~w, w, s, pg, d};
        @(posedge ref_clk_i);
        // strobes drop to zero, page and data are inverted so stale values cannot pass
        #1 req_o.rd = 1'b0;
        req_o.wr = 1'b0;
        req_o.page = ~pg;
        req_o.data = ~d;
        for (n = 0; n < 8 && ack_i !== 1'b1; n++) begin
            @(posedge ref_clk_i);
            #1;
        end
        q = (ack_i === 1'b1) ? rd_data_i : 8'hEE;
    endtask
endmodule

//--- vfs_pkg.sv
// vendor fault status register bank: shared constants and carriers
// assumes one clock domain; page and command codes come from the link logic
package vfs_pkg;
    localparam int          NCH        = 2;
    localparam int          NPH        = 6;
    localparam int          PCW        = 3;
    localparam int          TW         = 8;
    localparam int          NSYNC      = 2 * NCH;

    localparam logic [7:0]  PAGE_A     = 8'h00;
    localparam logic [7:0]  PAGE_B     = 8'h01;
    localparam logic [7:0]  PAGE_ALL   = 8'hFF;

    localparam int          BIT_PS     = 7;
    localparam int          BIT_OPEN   = 6;
    localparam int          BIT_CLAMP  = 5;
    localparam int          BIT_TSNS   = 4;
    localparam int          BIT_VID    = 3;
    localparam int          BIT_IMB    = 0;

    // implemented bits; the reset-vid flag lives on channel A only
    localparam logic [7:0]  MASK_A     = 8'hF9;
    localparam logic [7:0]  MASK_B     = 8'hF1;
    localparam logic [7:0]  STATUS_RST = 8'h00;

    localparam logic [PCW-1:0] IMB_RUN = 3'h7;
    localparam logic [PCW-1:0] RUN_ONE = 3'h1;
    localparam logic [PCW-1:0] RUN_RST = 3'h0;
    localparam logic [PCW-1:0] PH_RST  = 3'h0;

    localparam logic        CMD_STATUS = 1'b0;
    localparam logic        CMD_DETAIL = 1'b1;

    // per-channel condition inputs from logic on the same clock
    typedef struct packed {
        logic             sense_open;
        logic             vid_reset;
        logic             tsns_check;
        logic             imb_sample;
        logic [NPH-1:0]   imb_phase;
        logic [PCW-1:0]   cfg_phases;
        logic [PCW-1:0]   max_phases;
    } vfs_evt_t;

    // one byte-sized read or write transaction
    typedef struct packed {
        logic             rd;
        logic             wr;
        logic             sel;
        logic [7:0]       page;
        logic [7:0]       data;
    } vfs_req_t;
endpackage

//--- vfs_status.sv
// vendor fault status register bank for a two-channel regulator controller
// assumes requests arrive one per cycle from the link logic on ref_clk_i;
// power-stage fault and temperature-sense comparator are asynchronous pins
// Operation
// [R1] bit 7 latches when the external power stage reports a fault.
// [R2] bit 6 latches when the output sense pin was open at power-up.
// [R3] a phase count above the hardware maximum latches bit 5 and is clamped.
// [R4] bit 4 latches the temperature-sense level seen before soft-start.
// [R5] bit 3 latches on a voltage-id reset and exists on channel A only.
// [R6] bit 0 latches after seven consecutive detection cycles of imbalance.
// [R7] the phases showing imbalance are recorded for a separate read.
// [R8] writing 1 to an implemented bit clears it, writing 0 leaves it.
// [R9] each rail reports the highest of its power-stage temperatures.
// [R10] page 00h picks channel A, 01h channel B, FFh reads channel A.
// [R11] the register is reached only by byte reads and byte writes.
// [R12] flags stay set until cleared and bits 2 and 1 read as zero.
`timescale 1ns/10ps
module vfs_status (
    input  wire logic                               ref_clk_i,
    input  wire logic                               reset_i,
    input  wire logic                               clk_en_i,
    input  wire logic [vfs_pkg::NCH-1:0]            stage_fault_pin_i,
    input  wire logic [vfs_pkg::NCH-1:0]            tsns_high_pin_i,
    input  vfs_pkg::vfs_evt_t [vfs_pkg::NCH-1:0]    evt_i,
    input  wire logic [vfs_pkg::NCH-1:0][vfs_pkg::NPH-1:0][vfs_pkg::TW-1:0]
                                                    stage_temp_i,
    input  vfs_pkg::vfs_req_t                       req_i,
    output logic                                    ack_o,
    output logic [7:0]                              rd_data_o,
    output logic [vfs_pkg::NCH-1:0][vfs_pkg::PCW-1:0] op_phases_o,
    output logic [vfs_pkg::NCH-1:0][vfs_pkg::TW-1:0]  rail_temp_o
);
    localparam int NCH = vfs_pkg::NCH;
    localparam int NPH = vfs_pkg::NPH;
    localparam int NS  = vfs_pkg::NSYNC;
    // last run value before the seventh warning sample
    localparam logic [vfs_pkg::PCW-1:0] IMB_LAST =
        vfs_pkg::IMB_RUN - vfs_pkg::RUN_ONE;

    logic [NS-1:0]           s1_r, s2_r, s3_r, filt_r;
    logic [NS-1:0]           s1_nxt, s2_nxt, s3_nxt, filt_nxt;
    logic [7:0]              flags_r   [NCH];
    logic [7:0]              flags_nxt [NCH];
    logic [vfs_pkg::PCW-1:0] run_r     [NCH];
    logic [vfs_pkg::PCW-1:0] run_nxt   [NCH];
    logic [NPH-1:0]          detail_r  [NCH];
    logic [NPH-1:0]          detail_nxt[NCH];
    logic [vfs_pkg::PCW-1:0] oph_r     [NCH];
    logic [vfs_pkg::PCW-1:0] oph_nxt   [NCH];
    logic [vfs_pkg::TW-1:0]  tmax_r    [NCH];
    logic [vfs_pkg::TW-1:0]  tmax_nxt  [NCH];
    logic [7:0]              set_w     [NCH];
    logic [7:0]              clr_w     [NCH];
    logic [7:0]              rd_data_r, rd_data_nxt;
    logic                    ack_r, ack_nxt;

    // a write at page FFh reaches every channel, a read answers channel A
    function automatic logic page_hits(input logic [7:0] page,
                                       input int ch, input logic is_wr);
        logic hit;
        hit = 1'b0;
        if (page == vfs_pkg::PAGE_ALL) begin
            hit = is_wr || (ch == 0);
        end else if (page == vfs_pkg::PAGE_A) begin
            hit = (ch == 0);
        end else if (page == vfs_pkg::PAGE_B) begin
            hit = (ch == 1);
        end
        return hit;
    endfunction

    function automatic logic [vfs_pkg::TW-1:0] hottest(
        input logic [NPH-1:0][vfs_pkg::TW-1:0] t);
        logic [vfs_pkg::TW-1:0] m;
        m = t[0];
        for (int p = 1; p < NPH; p++) begin
            if (t[p] > m) begin
                m = t[p];
            end
        end
        return m;
    endfunction

    function automatic logic [7:0] impl_mask(input int ch);
        return (ch == 0) ? vfs_pkg::MASK_A : vfs_pkg::MASK_B;
    endfunction

    // low bits carry stage fault, high bits the temperature comparator
    always_comb begin
        s1_nxt   = {tsns_high_pin_i, stage_fault_pin_i};
        s2_nxt   = s1_r;
        s3_nxt   = s2_r;
        filt_nxt = filt_r;
        for (int i = 0; i < NS; i++) begin
            // a change counts only once two settled stages agree
            if (s2_r[i] == s3_r[i]) begin
                filt_nxt[i] = s3_r[i];
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            s1_r   <= '0;
            s2_r   <= '0;
            s3_r   <= '0;
            filt_r <= '0;
        end else if (clk_en_i) begin
            s1_r   <= s1_nxt;
            s2_r   <= s2_nxt;
            s3_r   <= s3_nxt;
            filt_r <= filt_nxt;
        end
    end

    always_comb begin
        rd_data_nxt = 8'h00;
        ack_nxt     = req_i.rd || req_i.wr; // see [R11]
        for (int c = 0; c < NCH; c++) begin
            set_w[c] = 8'h00;
            set_w[c][vfs_pkg::BIT_PS]   = filt_r[c]; // see [R1]
            set_w[c][vfs_pkg::BIT_OPEN] = evt_i[c].sense_open; // see [R2]
            set_w[c][vfs_pkg::BIT_CLAMP] =
                evt_i[c].cfg_phases > evt_i[c].max_phases; // see [R3]
            set_w[c][vfs_pkg::BIT_TSNS] =
                evt_i[c].tsns_check && filt_r[NCH + c]; // see [R4]
            set_w[c][vfs_pkg::BIT_VID]  = evt_i[c].vid_reset;
            set_w[c][vfs_pkg::BIT_IMB]  = evt_i[c].imb_sample
                && (|evt_i[c].imb_phase)
                && (run_r[c] == IMB_LAST); // see [R6]
            set_w[c] = set_w[c] & impl_mask(c); // see [R5]
            clr_w[c] = 8'h00;
            if (req_i.wr && req_i.sel == vfs_pkg::CMD_STATUS
                && page_hits(req_i.page, c, 1'b1)) begin
                clr_w[c] = req_i.data & impl_mask(c); // see [R8]
            end
            // set wins over a clear in the same cycle
            flags_nxt[c] = set_w[c] | (flags_r[c] & ~clr_w[c]); // see [R12]

            run_nxt[c] = run_r[c];
            if (evt_i[c].imb_sample) begin
                if (!(|evt_i[c].imb_phase)) begin
                    run_nxt[c] = vfs_pkg::RUN_RST;
                end else if (run_r[c] != vfs_pkg::IMB_RUN) begin
                    run_nxt[c] = run_r[c] + vfs_pkg::RUN_ONE; // see [R6]
                end
            end

            // detail follows the imbalance flag's clear
            detail_nxt[c] = detail_r[c];
            if (clr_w[c][vfs_pkg::BIT_IMB]) begin
                detail_nxt[c] = '0;
            end
            if (evt_i[c].imb_sample) begin
                detail_nxt[c] = detail_nxt[c] | evt_i[c].imb_phase; // see [R7]
            end

            oph_nxt[c] = set_w[c][vfs_pkg::BIT_CLAMP]
                ? evt_i[c].max_phases : evt_i[c].cfg_phases; // see [R3]
            tmax_nxt[c] = hottest(stage_temp_i[c]); // see [R9]

            if (req_i.rd && page_hits(req_i.page, c, 1'b0)) begin
                if (req_i.sel == vfs_pkg::CMD_DETAIL) begin
                    rd_data_nxt = {{(8-NPH){1'b0}}, detail_r[c]};
                end else begin
                    rd_data_nxt = flags_r[c]; // see [R10]
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            for (int c = 0; c < NCH; c++) begin
                flags_r[c]  <= vfs_pkg::STATUS_RST;
                run_r[c]    <= vfs_pkg::RUN_RST;
                detail_r[c] <= '0;
                oph_r[c]    <= vfs_pkg::PH_RST;
                tmax_r[c]   <= '0;
            end
            rd_data_r <= 8'h00;
            ack_r     <= 1'b0;
        end else if (clk_en_i) begin
            for (int c = 0; c < NCH; c++) begin
                flags_r[c]  <= flags_nxt[c];
                run_r[c]    <= run_nxt[c];
                detail_r[c] <= detail_nxt[c];
                oph_r[c]    <= oph_nxt[c];
                tmax_r[c]   <= tmax_nxt[c];
            end
            rd_data_r <= rd_data_nxt;
            ack_r     <= ack_nxt;
        end
    end

    always_comb begin
        ack_o     = ack_r;
        rd_data_o = rd_data_r;
        for (int c = 0; c < NCH; c++) begin
            op_phases_o[c] = oph_r[c];
            rail_temp_o[c] = tmax_r[c];
        end
    end

    stage_fault_a: assert property (@(posedge ref_clk_i) // see [R1]
        disable iff (reset_i)
        clk_en_i && filt_r[1] |=> flags_r[1][vfs_pkg::BIT_PS])
        else $error("stage fault not latched");

    flag_sticky_a: assert property (@(posedge ref_clk_i) // see [R12]
        disable iff (reset_i)
        flags_r[0][vfs_pkg::BIT_OPEN] && !clr_w[0][vfs_pkg::BIT_OPEN]
        |=> flags_r[0][vfs_pkg::BIT_OPEN])
        else $error("latched flag dropped without clear");

    phase_clamp_a: assert property (@(posedge ref_clk_i) // see [R3]
        disable iff (reset_i)
        clk_en_i && evt_i[0].cfg_phases > evt_i[0].max_phases
        |=> oph_r[0] == $past(evt_i[0].max_phases)
            && flags_r[0][vfs_pkg::BIT_CLAMP])
        else $error("phase count not clamped");

    vid_chan_a: assert property (@(posedge ref_clk_i) // see [R5]
        disable iff (reset_i)
        !flags_r[1][vfs_pkg::BIT_VID])
        else $error("reset-vid flag on channel B");

    reserved_zero_a: assert property (@(posedge ref_clk_i) // see [R12]
        disable iff (reset_i)
        ack_o && $past(clk_en_i)
        && $past(req_i.sel) == vfs_pkg::CMD_STATUS
        |-> rd_data_o[2:1] == 2'h0)
        else $error("reserved bits read nonzero");

    imb_run_a: assert property (@(posedge ref_clk_i) // see [R6]
        disable iff (reset_i)
        clk_en_i && evt_i[1].imb_sample && (|evt_i[1].imb_phase)
        && run_r[1] == IMB_LAST |=> flags_r[1][vfs_pkg::BIT_IMB])
        else $error("imbalance flag missed on seventh cycle");

    imb_early_a: assert property (@(posedge ref_clk_i) // see [R6]
        disable iff (reset_i)
        clk_en_i && !flags_r[1][vfs_pkg::BIT_IMB]
        && run_r[1] < IMB_LAST |=> !flags_r[1][vfs_pkg::BIT_IMB])
        else $error("imbalance flag set too early");

    byte_ack_a: assert property (@(posedge ref_clk_i) // see [R11]
        disable iff (reset_i)
        clk_en_i && (req_i.rd || req_i.wr) |=> ack_o)
        else $error("transaction not answered");

    write_clear_a: assert property (@(posedge ref_clk_i) // see [R8]
        disable iff (reset_i)
        clk_en_i && req_i.wr && req_i.sel == vfs_pkg::CMD_STATUS
        && req_i.page == vfs_pkg::PAGE_B && req_i.data[vfs_pkg::BIT_PS]
        && !filt_r[1] |=> !flags_r[1][vfs_pkg::BIT_PS])
        else $error("write of one did not clear");

    page_read_a: assert property (@(posedge ref_clk_i) // see [R10]
        disable iff (reset_i)
        clk_en_i && req_i.rd && req_i.page == vfs_pkg::PAGE_ALL
        && req_i.sel == vfs_pkg::CMD_STATUS
        |=> rd_data_o == $past(flags_r[0]))
        else $error("page FFh did not read channel A");

    rail_temp_a: assert property (@(posedge ref_clk_i) // see [R9]
        disable iff (reset_i)
        clk_en_i |=> rail_temp_o[0] >= $past(stage_temp_i[0][NPH-1])
            && rail_temp_o[0] >= $past(stage_temp_i[0][0]))
        else $error("rail temperature below a stage");

    freeze_a: assert property (@(posedge ref_clk_i)
        disable iff (reset_i)
        !clk_en_i |=> $stable(flags_r[0]) && $stable(ack_o))
        else $error("state moved with clock enable low");
endmodule
